// ===== rtl/cmu_pkg.sv
// Constants for the configuration memory update command handler.
package cmu_pkg;
   // Command codes in byte four
   localparam logic [7:0] CMD_DISCOVERY = 8'h02;
   localparam logic [7:0] CMD_SET_ADDR = 8'h03;
   localparam logic [7:0] CMD_ERASE = 8'h04;
   localparam logic [7:0] CMD_PROGRAM = 8'h05;
   localparam logic [7:0] CMD_NONE = 8'hFF;
   // Byte offsets within the datagram
   localparam int IDX_W = 9;
   localparam logic [IDX_W-1:0] IDX_SEQ_LAST = 9'h003;
   localparam logic [IDX_W-1:0] IDX_CMD = 9'h004;
   localparam logic [IDX_W-1:0] IDX_ARG_FIRST = 9'h005;
   localparam logic [IDX_W-1:0] IDX_COUNT_LAST = 9'h008;
   localparam logic [IDX_W-1:0] IDX_DATA_FIRST = 9'h009;
   localparam logic [IDX_W-1:0] IDX_DATA_LAST = 9'h108;
   localparam logic [IDX_W-1:0] IDX_ADDR_LAST = 9'h00E;
   localparam logic [IDX_W-1:0] IDX_MAX = 9'h1FF;
   // Block size in bytes
   localparam int BLOCK_BYTES = 256;
   // Reply kinds
   localparam logic [1:0] RPL_DISCOVERY = 2'h0;
   localparam logic [1:0] RPL_ERASE_ACK = 2'h1;
   localparam logic [1:0] RPL_ERASE_DONE = 2'h2;
   localparam logic [1:0] RPL_PROG_NEXT = 2'h3;
   // Reset values
   localparam logic [31:0] SEQ_RESET = 32'h0000_0000;
   localparam logic [31:0] NET_ADDR_DHCP = 32'h0000_0000;
   // Buffering
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 8;
endpackage : cmu_pkg

// ===== rtl/cmu_fifo_if.sv
// Carrier between the command handler and its data FIFO.
`timescale 1ns/1ps
`default_nettype none
interface cmu_fifo_if #(
   parameter int W = 8,
   parameter int LW = 5
);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   logic [LW-1:0] level;
   modport fifo_side (input in_valid, input in_data, input out_ready,
                      output in_ready, output out_valid, output out_data, output level);
   modport user_side (output in_valid, output in_data, output out_ready,
                      input in_ready, input out_valid, input out_data, input level);
endinterface : cmu_fifo_if
`default_nettype wire

// ===== rtl/cmu_fifo.sv
// Synchronous FIFO buffering program data toward the memory writer.
`timescale 1ns/1ps
`default_nettype none
module cmu_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Both sides
   cmu_fifo_if.fifo_side f
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_L = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
   logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
   logic [AW:0] count_reg, count_next;
   logic do_wr, do_rd;

   assign f.in_ready = (count_reg != DEPTH_L);
   assign f.out_valid = (count_reg != '0);
   assign f.out_data = mem[rd_ptr_reg];
   assign f.level = count_reg;

   always_comb begin
      do_wr = f.in_valid && f.in_ready;
      do_rd = f.out_valid && f.out_ready;
      wr_ptr_next = do_wr ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_next = do_rd ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
      count_next = count_reg;
      if (do_wr && !do_rd) begin
         count_next = (AW+1)'(count_reg + 1'b1);
      end else if (do_rd && !do_wr) begin
         count_next = (AW+1)'(count_reg - 1'b1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem[wr_ptr_reg] <= f.in_data;
      end
   end
endmodule : cmu_fifo
`default_nettype wire

// ===== rtl/cmu_cmd_top.sv
// Control-port command handler: erase, program and set-address of configuration memory.
//
// Overview of operation
// (R1) Command 0x04 in byte four erases the configuration memory.
// (R2) Erase gets a receipt reply, then a completion reply.
// (R3) Host times out an erase after about fifteen seconds and retries.
// (R4) Host sends erase and program unicast to the device address, control port.
// (R5) Host puts a zero sequence number in erase and set-address packets.
// (R6) Program is code 0x05, block count, then 256 data bytes ending at 264.
// (R7) Bytes five to eight carry the big-endian total block count.
// (R8) Each program packet gets a reply requesting the next block.
// (R9) Program sequence number starts at zero, increments, wraps at maximum.
// (R10) The control decoder keeps its own expected sequence counter.
// (R11) Sequence restarts at zero for every programming sequence.
// (R12) Host aborts programming when the echoed sequence differs.
// (R13) Host restart runs a full erase then a full program.
// (R14) Set-address is code 0x03, broadcast to all-ones on the control port.
// (R15) Set-address acts only when bytes five to ten match own hardware address.
// (R16) Matching set-address stores bytes eleven to fourteen into memory.
// (R17) A stored all-zero address selects dynamic addressing.
// (R18) Committed new address is reported in later discovery replies.
// (R19) Host discovers and records the hardware address before re-addressing.
// (R20) Discovery is code 0x02; its reply carries the current address.
// (R21) Blocks go to consecutive memory from base; excess blocks are ignored.
// (R22) Unknown command codes are dropped without any reply.
`timescale 1ns/1ps
`default_nettype none
module cmu_cmd_top #(
   parameter int NVM_AW = 24,
   parameter int FIFO_DEPTH = cmu_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   // Control-port datagram bytes
   input wire logic RX_VALID_I,
   input wire logic [7:0] RX_DATA_I,
   input wire logic RX_LAST_I,
   output logic RX_READY_O,
   // Reply requests
   output logic TX_VALID_O,
   output logic [1:0] TX_KIND_O,
   output logic [31:0] TX_SEQ_O,
   output logic [31:0] TX_NET_ADDR_O,
   input wire logic TX_READY_I,
   // Identity
   input wire logic [47:0] HW_ADDR_I,
   input wire logic [31:0] NET_ADDR_INIT_I,
   // Configuration memory
   output logic NVM_ERASE_O,
   output logic NVM_ADDR_WR_O,
   output logic [31:0] NVM_NET_ADDR_O,
   output logic NVM_WR_VALID_O,
   output logic [NVM_AW-1:0] NVM_WR_ADDR_O,
   output logic [7:0] NVM_WR_DATA_O,
   input wire logic NVM_WR_READY_I,
   input wire logic NVM_DONE_I,
   // Status
   output logic [31:0] NET_ADDR_O,
   output logic DHCP_EN_O,
   output logic SEQ_ERR_O
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   // Two slots of slack cover the registered ready
   localparam logic [LW-1:0] FILL_LIMIT = LW'(FIFO_DEPTH - 2);
   typedef enum {S_RX, S_DRAIN, S_ERASE_ACK, S_ERASE_WAIT, S_ADDR_WAIT, S_REPLY} cmu_state_t;
   cmu_fifo_if #(.W(cmu_pkg::FIFO_WIDTH), .LW(LW)) fifo_bus ();
   cmu_fifo #(
      .WIDTH(cmu_pkg::FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESETN_I),
      .f(fifo_bus.fifo_side)
   );
   cmu_state_t state_reg, state_next;
   logic [cmu_pkg::IDX_W-1:0] idx_reg, idx_next;
   logic [7:0] cmd_reg, cmd_next, wr_data_reg, wr_data_next;
   logic [31:0] seq_reg, seq_next, exp_seq_reg, exp_seq_next, blocks_reg, blocks_next;
   logic [31:0] tx_seq_reg, tx_seq_next, nvm_net_reg, nvm_net_next, net_addr_reg, net_addr_next;
   logic [79:0] arg_reg, arg_next;
   logic take_reg, take_next, restart_reg, restart_next, rx_ready_reg, rx_ready_next;
   logic tx_valid_reg, tx_valid_next, erase_reg, erase_next, addr_wr_reg, addr_wr_next;
   logic loaded_reg, loaded_next, seq_err_reg, seq_err_next, dhcp_reg, dhcp_next, wr_valid_reg, wr_valid_next;
   logic [1:0] tx_kind_reg, tx_kind_next;
   logic acc, acc_last, push, pop;
   logic [NVM_AW-1:0] wr_addr_reg, wr_addr_next, base_reg, base_next;
   assign acc = (state_reg == S_RX) && RX_VALID_I && rx_ready_reg;
   assign acc_last = acc && RX_LAST_I;
   // (R6) Data bytes of a program
   // (R21) Excess blocks ignored
   assign push = acc && (cmd_reg == cmu_pkg::CMD_PROGRAM) && take_reg &&
                 (idx_reg >= cmu_pkg::IDX_DATA_FIRST) && (idx_reg <= cmu_pkg::IDX_DATA_LAST);
   assign fifo_bus.in_valid = push;
   assign fifo_bus.in_data = RX_DATA_I;
   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      cmd_next = cmd_reg;
      seq_next = seq_reg;
      arg_next = arg_reg;
      exp_seq_next = exp_seq_reg;
      blocks_next = blocks_reg;
      take_next = take_reg;
      restart_next = 1'b0;
      tx_valid_next = tx_valid_reg;
      tx_kind_next = tx_kind_reg;
      tx_seq_next = tx_seq_reg;
      erase_next = 1'b0;
      addr_wr_next = 1'b0;
      nvm_net_next = nvm_net_reg;
      net_addr_next = net_addr_reg;
      loaded_next = 1'b1;
      seq_err_next = seq_err_reg;
      if (!loaded_reg) begin
         net_addr_next = NET_ADDR_INIT_I;
      end
      if (acc) begin
         idx_next = (idx_reg == cmu_pkg::IDX_MAX) ? idx_reg : cmu_pkg::IDX_W'(idx_reg + 1'b1);
         if (idx_reg == '0) begin
            cmd_next = cmu_pkg::CMD_NONE;
            take_next = 1'b0;
         end
         if (idx_reg <= cmu_pkg::IDX_SEQ_LAST) begin
            seq_next = {seq_reg[23:0], RX_DATA_I};
         end
         if (idx_reg == cmu_pkg::IDX_CMD) begin
            cmd_next = RX_DATA_I;
            if (RX_DATA_I == cmu_pkg::CMD_PROGRAM) begin
               // (R11) Zero starts a sequence
               if (seq_reg == cmu_pkg::SEQ_RESET) begin
                  blocks_next = '0;
                  restart_next = 1'b1;
                  seq_err_next = 1'b0;
               // (R10) Missing packet detect
               end else if (seq_reg != exp_seq_reg) begin
                  seq_err_next = 1'b1;
               end
               // (R9) Wraps naturally
               exp_seq_next = seq_reg + 32'h0000_0001;
            end
         end
         // (R7) Count, then address fields
         if ((idx_reg >= cmu_pkg::IDX_ARG_FIRST) && (idx_reg <= cmu_pkg::IDX_ADDR_LAST) &&
             !((cmd_reg == cmu_pkg::CMD_PROGRAM) && (idx_reg > cmu_pkg::IDX_COUNT_LAST))) begin
            arg_next = {arg_reg[71:0], RX_DATA_I};
         end
         if ((cmd_reg == cmu_pkg::CMD_PROGRAM) && (idx_reg == cmu_pkg::IDX_COUNT_LAST)) begin
            take_next = (blocks_reg < {arg_reg[23:0], RX_DATA_I});
         end
      end
      case (state_reg)
         S_RX: begin
            if (acc_last) begin
               idx_next = '0;
               tx_seq_next = seq_reg;
               case (cmd_next)
                  cmu_pkg::CMD_DISCOVERY: begin
                     // (R20) Reply with current address
                     tx_kind_next = cmu_pkg::RPL_DISCOVERY;
                     tx_valid_next = 1'b1;
                     state_next = S_REPLY;
                  end
                  cmu_pkg::CMD_ERASE: begin
                     // (R2) Receipt reply first
                     tx_kind_next = cmu_pkg::RPL_ERASE_ACK;
                     tx_valid_next = 1'b1;
                     exp_seq_next = cmu_pkg::SEQ_RESET;
                     blocks_next = '0;
                     restart_next = 1'b1;
                     seq_err_next = 1'b0;
                     state_next = S_ERASE_ACK;
                  end
                  cmu_pkg::CMD_PROGRAM: begin
                     if (take_next) begin
                        blocks_next = blocks_reg + 32'h0000_0001;
                     end
                     state_next = S_DRAIN;
                  end
                  // (R14) Set-address code
                  cmu_pkg::CMD_SET_ADDR: begin
                     // (R15) Hardware address match
                     if (arg_next[79:32] == HW_ADDR_I) begin
                        // (R16) Commit new address
                        nvm_net_next = arg_next[31:0];
                        addr_wr_next = 1'b1;
                        state_next = S_ADDR_WAIT;
                     end
                  end
                  // (R22) Unknown codes dropped
                  default: begin
                     state_next = S_RX;
                  end
               endcase
            end
         end
         S_DRAIN: begin
            // (R8) Request next block once written
            if (!fifo_bus.out_valid && !wr_valid_reg) begin
               tx_kind_next = cmu_pkg::RPL_PROG_NEXT;
               tx_valid_next = 1'b1;
               state_next = S_REPLY;
            end
         end
         S_ERASE_ACK: begin
            if (TX_READY_I) begin
               tx_valid_next = 1'b0;
               // (R1) Start the erase
               erase_next = 1'b1;
               state_next = S_ERASE_WAIT;
            end
         end
         S_ERASE_WAIT: begin
            // (R2) Completion reply
            if (NVM_DONE_I) begin
               tx_kind_next = cmu_pkg::RPL_ERASE_DONE;
               tx_valid_next = 1'b1;
               state_next = S_REPLY;
            end
         end
         S_ADDR_WAIT: begin
            // (R18) Report only once committed
            if (NVM_DONE_I) begin
               net_addr_next = nvm_net_reg;
               state_next = S_RX;
            end
         end
         S_REPLY: begin
            if (TX_READY_I) begin
               tx_valid_next = 1'b0;
               state_next = S_RX;
            end
         end
         default: begin
            state_next = S_RX;
         end
      endcase
      // Back-pressure keeps the FIFO from overflowing
      rx_ready_next = (state_next == S_RX) && (fifo_bus.level < FILL_LIMIT);
      // (R17) Zero address means dynamic
      dhcp_next = loaded_next && (net_addr_next == cmu_pkg::NET_ADDR_DHCP);
   end
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state_reg <= S_RX;
         idx_reg <= '0;
         cmd_reg <= cmu_pkg::CMD_NONE;
         seq_reg <= cmu_pkg::SEQ_RESET;
         arg_reg <= '0;
         exp_seq_reg <= cmu_pkg::SEQ_RESET;
         blocks_reg <= '0;
         take_reg <= 1'b0;
         restart_reg <= 1'b0;
         rx_ready_reg <= 1'b0;
         tx_valid_reg <= 1'b0;
         tx_kind_reg <= cmu_pkg::RPL_DISCOVERY;
         tx_seq_reg <= cmu_pkg::SEQ_RESET;
         erase_reg <= 1'b0;
         addr_wr_reg <= 1'b0;
         nvm_net_reg <= cmu_pkg::NET_ADDR_DHCP;
         net_addr_reg <= cmu_pkg::NET_ADDR_DHCP;
         loaded_reg <= 1'b0;
         seq_err_reg <= 1'b0;
         dhcp_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         cmd_reg <= cmd_next;
         seq_reg <= seq_next;
         arg_reg <= arg_next;
         exp_seq_reg <= exp_seq_next;
         blocks_reg <= blocks_next;
         take_reg <= take_next;
         restart_reg <= restart_next;
         rx_ready_reg <= rx_ready_next;
         tx_valid_reg <= tx_valid_next;
         tx_kind_reg <= tx_kind_next;
         tx_seq_reg <= tx_seq_next;
         erase_reg <= erase_next;
         addr_wr_reg <= addr_wr_next;
         nvm_net_reg <= nvm_net_next;
         net_addr_reg <= net_addr_next;
         loaded_reg <= loaded_next;
         seq_err_reg <= seq_err_next;
         dhcp_reg <= dhcp_next;
      end
   end
   // Writer drains the FIFO at the memory's own pace
   always_comb begin
      pop = fifo_bus.out_valid && (!wr_valid_reg || NVM_WR_READY_I);
      wr_valid_next = wr_valid_reg;
      wr_data_next = wr_data_reg;
      wr_addr_next = wr_addr_reg;
      base_next = base_reg;
      // (R21) Restart from memory base
      if (restart_reg) begin
         base_next = '0;
      end
      if (pop) begin
         wr_valid_next = 1'b1;
         wr_data_next = fifo_bus.out_data;
         // (R21) Consecutive locations
         wr_addr_next = base_next;
         base_next = NVM_AW'(base_next + 1'b1);
      end else if (NVM_WR_READY_I) begin
         wr_valid_next = 1'b0;
      end
   end
   assign fifo_bus.out_ready = pop;
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wr_valid_reg <= 1'b0;
         wr_data_reg <= 8'h00;
         wr_addr_reg <= '0;
         base_reg <= '0;
      end else begin
         wr_valid_reg <= wr_valid_next;
         wr_data_reg <= wr_data_next;
         wr_addr_reg <= wr_addr_next;
         base_reg <= base_next;
      end
   end
   assign RX_READY_O = rx_ready_reg;
   assign TX_VALID_O = tx_valid_reg;
   assign TX_KIND_O = tx_kind_reg;
   assign TX_SEQ_O = tx_seq_reg;
   assign TX_NET_ADDR_O = net_addr_reg;
   assign NVM_ERASE_O = erase_reg;
   assign NVM_ADDR_WR_O = addr_wr_reg;
   assign NVM_NET_ADDR_O = nvm_net_reg;
   assign NVM_WR_VALID_O = wr_valid_reg;
   assign NVM_WR_ADDR_O = wr_addr_reg;
   assign NVM_WR_DATA_O = wr_data_reg;
   assign NET_ADDR_O = net_addr_reg;
   assign SEQ_ERR_O = seq_err_reg;
   assign DHCP_EN_O = dhcp_reg;
endmodule : cmu_cmd_top
`default_nettype wire

// ===== verification/cmu_cmd_assertions.sv
// Port checks for the command handler.
`timescale 1ns/1ps
`default_nettype none
module cmu_cmd_checker #(
   parameter int NVM_AW = 24
) (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   // Watched ports
   input wire logic RX_READY_O,
   input wire logic TX_VALID_O,
   input wire logic [1:0] TX_KIND_O,
   input wire logic [31:0] TX_SEQ_O,
   input wire logic [31:0] TX_NET_ADDR_O,
   input wire logic TX_READY_I,
   input wire logic [31:0] NET_ADDR_INIT_I,
   input wire logic NVM_ERASE_O,
   input wire logic NVM_ADDR_WR_O,
   input wire logic [31:0] NVM_NET_ADDR_O,
   input wire logic NVM_WR_VALID_O,
   input wire logic [NVM_AW-1:0] NVM_WR_ADDR_O,
   input wire logic [7:0] NVM_WR_DATA_O,
   input wire logic NVM_WR_READY_I,
   input wire logic NVM_DONE_I,
   input wire logic [31:0] NET_ADDR_O,
   input wire logic DHCP_EN_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);
   chk_erase_after_ack: assert property ($rose(NVM_ERASE_O) |-> $past(TX_VALID_O && TX_READY_I)
      && $past(TX_KIND_O) == cmu_pkg::RPL_ERASE_ACK) else $error("erase started without accepted receipt");
   chk_erase_one_pulse: assert property (NVM_ERASE_O |=> !NVM_ERASE_O)
      else $error("erase pulse too long");
   chk_done_reply_cause: assert property ($rose(TX_VALID_O) && TX_KIND_O == cmu_pkg::RPL_ERASE_DONE
      |-> $past(NVM_DONE_I)) else $error("erase done reply without memory done");
   chk_reply_stands: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_KIND_O)
      && $stable(TX_SEQ_O)) else $error("reply changed before acceptance");
   chk_write_stands: assert property (NVM_WR_VALID_O && !NVM_WR_READY_I |=> NVM_WR_VALID_O
      && $stable(NVM_WR_ADDR_O) && $stable(NVM_WR_DATA_O)) else $error("write changed before acceptance");
   chk_rx_held_off: assert property (TX_VALID_O |-> !RX_READY_O)
      else $error("bytes taken while reply pending");
   chk_dhcp_zero: assert property (DHCP_EN_O |-> NET_ADDR_O == cmu_pkg::NET_ADDR_DHCP)
      else $error("dynamic addressing with nonzero address");
   chk_disc_addr: assert property (TX_VALID_O && TX_KIND_O == cmu_pkg::RPL_DISCOVERY
      |-> TX_NET_ADDR_O == NET_ADDR_O) else $error("discovery reply address stale");
   chk_addr_source: assert property ($changed(NET_ADDR_O) |-> NET_ADDR_O == NVM_NET_ADDR_O
      || NET_ADDR_O == NET_ADDR_INIT_I) else $error("address from unknown source");
   chk_addr_wr_pulse: assert property (NVM_ADDR_WR_O |=> !NVM_ADDR_WR_O)
      else $error("address store pulse too long");
endmodule : cmu_cmd_checker
bind cmu_cmd_top cmu_cmd_checker #(.NVM_AW(NVM_AW)) u_chk (.CORE_CLK_I, .RESETN_I, .RX_READY_O, .TX_VALID_O,
   .TX_KIND_O, .TX_SEQ_O, .TX_NET_ADDR_O, .TX_READY_I, .NET_ADDR_INIT_I, .NVM_ERASE_O, .NVM_ADDR_WR_O,
   .NVM_NET_ADDR_O, .NVM_WR_VALID_O, .NVM_WR_ADDR_O, .NVM_WR_DATA_O, .NVM_WR_READY_I, .NVM_DONE_I,
   .NET_ADDR_O, .DHCP_EN_O);
`default_nettype wire

// ===== verification/cmu_nvm_model.sv
// Behavioural configuration memory behind the handler.
`timescale 1ns/1ps
`default_nettype none
module cmu_nvm_model #(
   parameter int DONE_DLY = 40
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Requests
   input wire logic slow_i,
   input wire logic erase_i,
   input wire logic addr_wr_i,
   input wire logic [31:0] net_addr_i,
   // Answers
   output logic wr_ready_o,
   output logic done_o,
   output logic [31:0] stored_addr_o
);
   int cnt;
   logic [3:0] stall;
   // slow erase or store, one done pulse
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= 0;
         done_o <= 1'b0;
         stall <= 4'h0;
         stored_addr_o <= 32'h0000_0000;
      end else begin
         done_o <= (cnt == 1);
         stall <= stall + 4'h1;
         if (erase_i || addr_wr_i) begin
            cnt <= DONE_DLY;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
         if (addr_wr_i) begin
            stored_addr_o <= net_addr_i;
         end
      end
   end
   // writes taken at once or with stalls
   assign wr_ready_o = !slow_i || (stall[3:2] == 2'h3);
endmodule : cmu_nvm_model
`default_nettype wire

// ===== verification/test_config_memory_update_commands.sv
// Self-checking bench for the command handler.
`timescale 1ns/1ps
`default_nettype none
module test_config_memory_update_commands;
   localparam logic [47:0] OWN_HW = 48'h0A1B_2C3D_4E5F;
   localparam logic [31:0] INIT_NET = 32'h0A00_0017;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rx_valid = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic rx_last = 1'b0;
   logic tx_ready = 1'b0;
   logic slow = 1'b0;
   logic rx_ready, tx_valid, nvm_erase, nvm_awr, wr_valid, wr_ready, done, dhcp, seq_err;
   logic [1:0] tx_kind;
   logic [7:0] wr_data;
   logic [23:0] wr_addr;
   logic [31:0] tx_seq, tx_net, nvm_net, net_addr, stored, exp_net, exp_wa, exp_seq, rng;
   logic [7:0] pkt[$];
   logic [7:0] exp_wq[$];
   logic exp_err;
   int fails = 0;
   int num_checks = 0;
   int blocks;
   cmu_cmd_top uut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data),
      .RX_LAST_I(rx_last), .RX_READY_O(rx_ready), .TX_VALID_O(tx_valid), .TX_KIND_O(tx_kind),
      .TX_SEQ_O(tx_seq), .TX_NET_ADDR_O(tx_net), .TX_READY_I(tx_ready), .HW_ADDR_I(OWN_HW),
      .NET_ADDR_INIT_I(INIT_NET), .NVM_ERASE_O(nvm_erase), .NVM_ADDR_WR_O(nvm_awr), .NVM_NET_ADDR_O(nvm_net),
      .NVM_WR_VALID_O(wr_valid), .NVM_WR_ADDR_O(wr_addr), .NVM_WR_DATA_O(wr_data), .NVM_WR_READY_I(wr_ready),
      .NVM_DONE_I(done), .NET_ADDR_O(net_addr), .DHCP_EN_O(dhcp), .SEQ_ERR_O(seq_err));
   cmu_nvm_model nvm (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .erase_i(nvm_erase), .addr_wr_i(nvm_awr),
      .net_addr_i(nvm_net), .wr_ready_o(wr_ready), .done_o(done), .stored_addr_o(stored));
   initial begin
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic summarize();
      if (fails == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic put(input logic [31:0] v, input int n);
      for (int i = 0; i < n; i++) pkt.push_back(v[31-8*i -: 8]);
   endtask : put
   task automatic start(input logic [31:0] seq, input logic [7:0] cmd);
      pkt.delete();
      put(seq, 4);
      pkt.push_back(cmd);
   endtask : start
   // Byte source holds each byte until taken
   task automatic send();
      int n;
      foreach (pkt[i]) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data = pkt[i];
         rx_last = (i == pkt.size() - 1);
         n = 0;
         // Ready seen at the falling edge holds through the next rising edge
         while (rx_ready !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
         end
         if (n >= 4000) fails++;
         @(posedge clk);
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_last = 1'b0;
      rx_data = ~rx_data;
   endtask : send
   task automatic reply(input logic [1:0] kind, input logic [31:0] seq);
      int n;
      n = 0;
      while (tx_valid !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 4000) fails++;
      check("reply kind", 32'(kind), 32'(tx_kind));
      check("reply seq", seq, tx_seq);
      if (kind == cmu_pkg::RPL_DISCOVERY) check("reply addr", exp_net, tx_net);
      rng = xs(rng);
      repeat (rng[1:0]) @(negedge clk);
      tx_ready = 1'b1;
      @(negedge clk);
      tx_ready = 1'b0;
   endtask : reply
   task automatic prog_block(input logic [31:0] seq, input logic [31:0] total);
      if (seq == 32'h0) begin
         exp_wa = 32'h0;
         blocks = 0;
         exp_err = 1'b0;
      end else if (seq != exp_seq) exp_err = 1'b1;
      exp_seq = seq + 32'h1;
      start(seq, cmu_pkg::CMD_PROGRAM);
      put(total, 4);
      for (int i = 0; i < cmu_pkg::BLOCK_BYTES; i++) begin
         rng = xs(rng);
         pkt.push_back(rng[7:0]);
         if (blocks < total) exp_wq.push_back(rng[7:0]);
      end
      blocks++;
      send();
      reply(cmu_pkg::RPL_PROG_NEXT, seq);
      check("pending writes", 32'h0, 32'(exp_wq.size()));
      check("seq error", 32'(exp_err), 32'(seq_err));
   endtask : prog_block
   task automatic setaddr(input logic [47:0] target_hw_address, input logic [31:0] assigned_net_address);
      start(32'h0, cmu_pkg::CMD_SET_ADDR);
      put(target_hw_address[47:16], 4);
      put({target_hw_address[15:0], 16'h0000}, 2);
      put(assigned_net_address, 4);
      send();
      if (target_hw_address == OWN_HW) exp_net = assigned_net_address;
      repeat (60) @(negedge clk);
      check("net addr", exp_net, net_addr);
      check("stored addr", exp_net, stored);
      check("dhcp", 32'(exp_net == 32'h0), 32'(dhcp));
   endtask : setaddr
   task automatic discover();
      rng = xs(rng);
      start(rng, cmu_pkg::CMD_DISCOVERY);
      send();
      reply(cmu_pkg::RPL_DISCOVERY, rng);
   endtask : discover
   task automatic erase();
      start(32'h0, cmu_pkg::CMD_ERASE);
      put(32'h0, 4);
      send();
      reply(cmu_pkg::RPL_ERASE_ACK, 32'h0);
      reply(cmu_pkg::RPL_ERASE_DONE, 32'h0);
   endtask : erase
   always @(posedge clk) begin
      if (rst_n && wr_valid && wr_ready) begin
         if (exp_wq.size() == 0) check("extra write", 32'h0, 32'h1);
         else begin
            check("write addr", exp_wa, {8'h00, wr_addr});
            check("write data", 32'(exp_wq.pop_front()), 32'(wr_data));
            exp_wa++;
         end
      end
   end
   initial begin
      #(60000 * 50);
      fails++;
      summarize();
   end
   initial begin
      logic [7:0] bad_codes[3] = '{8'h00, 8'h06, 8'hA5};
      rng = 32'h838e;
      exp_net = INIT_NET;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      check("boot addr", INIT_NET, net_addr);
      discover();
      foreach (bad_codes[i]) begin
         start(32'h0, bad_codes[i]);
         put(32'h0, 4);
         send();
         repeat (20) @(negedge clk);
         check("no reply", 32'h0, 32'(tx_valid));
         check("still idle", 32'h1, 32'(rx_ready));
      end
      erase();
      slow = 1'b1;
      prog_block(32'h0, 32'h2);
      prog_block(32'h1, 32'h2);
      prog_block(32'h2, 32'h2);
      prog_block(32'h7, 32'h2);
      prog_block(32'h8, 32'h2);
      slow = 1'b0;
      erase();
      prog_block(32'h0, 32'h1);
      discover();
      setaddr(OWN_HW, 32'h0);
      discover();
      rng = xs(rng);
      setaddr(OWN_HW ^ 48'h1, rng);
      rng = xs(rng);
      setaddr(OWN_HW, rng | 32'h1);
      discover();
      summarize();
   end
endmodule : test_config_memory_update_commands
`default_nettype wire
